//--- sctr_regs.sv
// synth calibration and gain-step test register bank with calibration sequencing
// Operation
// - two 5-bit gain steps: mid-to-top bits 9:5 reset 9, bottom-to-mid 4:0 reset 10
// - settle-extend bit 11 doubles oscillator settling time per array calibration step
// - array override enable bit 10 selects 5-bit override value, reset 16
// - last calibrated array setting readable, read-only, at bits 4:0
// - calibrate on rx and tx entry; skip bit limits tx to the strobe
// - long-measure bit, reset 1, gives 57 us calibration, else 37 us
// - with node test input low, dac select picks dac value over loop filter
// - 2-bit current calibration speed: normal, double, half, 3 undefined
// - current override bit 12 uses 6-bit current A value; result readable
// - current constant bits 9:4 doubles as current B override value
// - pump-off bit 15, reset 1, disables charge pump during calibration
// - pump current from calibration, or from initial current when override set
// - force-up, force-down outputs; pulse mask hides both phase detector pulses
// - phase detector reset delay short when bit 10 is zero, long when one
// - step period code: 0.25, 0.5, 1, 4 us; reset code 2
// - after calibration load initial current, step down one per period to final
`timescale 1ns/100ps
`default_nettype none
module sctr_regs import sctr_pkg::*; #(
  parameter int CAL_SHORT_CYC = ns_to_cyc(CAL_SHORT_NS),
  parameter int CAL_LONG_CYC  = ns_to_cyc(CAL_LONG_NS)
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // configuration port
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [5:0]  cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  output logic [15:0]      cfg_rdata_q,
  // radio control events
  input  wire logic        rx_entry,
  input  wire logic        tx_entry,
  input  wire logic        tx_calibrate_strobe,
  input  wire logic        ctrl_node_test_input,
  // analog calibration results
  input  wire logic [4:0]  array_cal_in,
  input  wire logic [5:0]  current_cal_in,
  // gain control
  output logic [4:0]       mid_to_top_gain_step,
  output logic [4:0]       bottom_to_mid_gain_step,
  // oscillator controls
  output logic             cal_busy_q,
  output logic             settle_phase_q,
  output logic [4:0]       array_setting_q,
  output logic [1:0]       current_cal_speed,
  output logic [3:0]       osc_current_reference,
  output logic [5:0]       osc_current_a_q,
  output logic [5:0]       osc_current_b_q,
  output logic             ctrl_node_use_dac_q,
  output logic [2:0]       ctrl_node_dac_value,
  // charge pump controls
  output logic             pump_enable_q,
  output logic [3:0]       pump_current_q,
  output logic             pump_force_up,
  output logic             pump_force_down,
  output logic             pump_pulse_mask,
  output logic             phase_det_delay_select
);

  sctr_gain_s    gain_q;
  sctr_array_s   array_q;
  sctr_cal_s     cal_q;
  sctr_current_s cur_q;
  sctr_pump_s    pump_q;
  sctr_cal_e     state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             cal_done;
  logic             trigger;
  logic [3:0]       step_cur;
  logic             stepping;
  sctr_array_s      wr_array;
  sctr_current_s    wr_cur;

  // write data seen through the register layouts
  assign wr_array = cfg_wdata;
  assign wr_cur   = cfg_wdata;

  function automatic logic wr_hit(input logic [5:0] a);
    return cfg_wr && cfg_addr == a;
  endfunction

  // register writes; reserved and read-only fields keep their value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gain_q <= GAIN_RST;
    end else if (wr_hit(ADDR_GAIN)) begin
      gain_q <= cfg_wdata;
      gain_q.rsvd <= '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      array_q <= ARRAY_RST;
    end else begin
      if (wr_hit(ADDR_ARRAY)) begin
        array_q.array_settle_extend <= wr_array.array_settle_extend;
        array_q.array_override_en   <= wr_array.array_override_en;
        array_q.array_override_val  <= wr_array.array_override_val;
      end
      if (cal_done) begin
        array_q.array_cal_result <= array_cal_in;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cal_q <= CAL_RST;
    end else if (wr_hit(ADDR_CAL)) begin
      cal_q <= cfg_wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= CURRENT_RST;
    end else begin
      if (wr_hit(ADDR_CURRENT)) begin
        cur_q.current_cal_speed        <= wr_cur.current_cal_speed;
        cur_q.osc_current_override_en  <= wr_cur.osc_current_override_en;
        cur_q.osc_current_a_override   <= wr_cur.osc_current_a_override;
      end
      if (cal_done) begin
        cur_q.osc_current_cal_result <= current_cal_in;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pump_q <= PUMP_RST;
    end else if (wr_hit(ADDR_PUMP)) begin
      pump_q <= cfg_wdata;
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata_q <= 16'h0000;
    end else if (cfg_rd) begin
      unique case (cfg_addr)
        ADDR_GAIN:    cfg_rdata_q <= gain_q;
        ADDR_ARRAY:   cfg_rdata_q <= array_q;
        ADDR_CAL:     cfg_rdata_q <= cal_q;
        ADDR_CURRENT: cfg_rdata_q <= cur_q;
        ADDR_PUMP:    cfg_rdata_q <= pump_q;
        default:      cfg_rdata_q <= 16'h0000;
      endcase
    end
  end

  // calibration request; the host keeps reserved bits zero, so no extra masking is needed
  assign trigger = rx_entry || tx_calibrate_strobe
                 || (tx_entry && !cal_q.skip_tx_calibration);

  // calibration sequencer: measurement time, then optional extra settling
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CAL_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        CAL_IDLE: begin
          if (trigger) begin
            state_q <= CAL_MEASURE;
            cnt_q   <= cal_q.long_freq_measure ? CNT_W'(CAL_LONG_CYC - 1)
                                               : CNT_W'(CAL_SHORT_CYC - 1);
          end
        end
        CAL_MEASURE: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (array_q.array_settle_extend) begin
            state_q <= CAL_SETTLE;
            cnt_q   <= CNT_W'(ARRAY_STEPS * ns_to_cyc(SETTLE_NS) - 1);
          end else begin
            state_q <= CAL_IDLE;
          end
        end
        CAL_SETTLE: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            state_q <= CAL_IDLE;
          end
        end
      endcase
    end
  end

  assign cal_done = (state_q != CAL_IDLE) && cnt_q == '0
                  && !(state_q == CAL_MEASURE && array_q.array_settle_extend);

  sctr_pump_stepper u_stepper (
    .clock       (clock),
    .arst_n      (arst_n),
    .start       (cal_done),
    .interval    (pump_q.pump_step_interval),
    .initial_cur (pump_q.pump_initial_current),
    .final_cur   (pump_q.pump_final_current),
    .current_q   (step_cur),
    .stepping_q  (stepping)
  );

  // registered analog controls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cal_busy_q          <= 1'b0;
      settle_phase_q      <= 1'b0;
      array_setting_q     <= 5'h00;
      osc_current_a_q     <= 6'h00;
      osc_current_b_q     <= 6'h00;
      ctrl_node_use_dac_q <= 1'b0;
      pump_enable_q       <= 1'b0;
      pump_current_q      <= 4'h0;
    end else begin
      cal_busy_q      <= state_q != CAL_IDLE;
      settle_phase_q  <= state_q == CAL_SETTLE;
      array_setting_q <= array_q.array_override_en ? array_q.array_override_val
                                                   : array_q.array_cal_result;
      osc_current_a_q <= cur_q.osc_current_override_en ? cur_q.osc_current_a_override
                                                       : cur_q.osc_current_cal_result;
      osc_current_b_q <= cal_q.osc_current_constant;
      ctrl_node_use_dac_q <= !ctrl_node_test_input && cal_q.ctrl_node_dac_select;
      pump_enable_q <= !(state_q != CAL_IDLE && pump_q.pump_off_during_cal);
      pump_current_q <= pump_q.pump_current_override_en ? pump_q.pump_initial_current
                                                        : step_cur;
    end
  end

  assign mid_to_top_gain_step    = gain_q.mid_to_top_gain_step;
  assign bottom_to_mid_gain_step = gain_q.bottom_to_mid_gain_step;
  assign current_cal_speed       = cur_q.current_cal_speed;
  assign osc_current_reference   = cal_q.osc_current_reference;
  assign ctrl_node_dac_value     = cal_q.ctrl_node_dac_value;
  assign pump_force_up           = pump_q.pump_force_up;
  assign pump_force_down         = pump_q.pump_force_down;
  assign pump_pulse_mask         = pump_q.pump_pulse_mask;
  assign phase_det_delay_select  = pump_q.phase_det_delay_select;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_gain_write;
    wr_hit(ADDR_GAIN) |=> mid_to_top_gain_step == $past(cfg_wdata[9:5])
                        && bottom_to_mid_gain_step == $past(cfg_wdata[4:0]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain step not stored");

  property p_array_ovr;
    array_q.array_override_en && $stable(array_q) |=> array_setting_q == $past(array_q.array_override_val);
  endproperty
  a_array_ovr: assert property (p_array_ovr) else $error("array override ignored");

  property p_ro_write;
    wr_hit(ADDR_ARRAY) && !cal_done |=> array_q.array_cal_result == $past(array_q.array_cal_result);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only field written");

  property p_rsvd_zero;
    cfg_rd && cfg_addr == ADDR_GAIN |=> cfg_rdata_q[15:10] == 6'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_skip_tx;
    state_q == CAL_IDLE && tx_entry && cal_q.skip_tx_calibration && !rx_entry
      && !tx_calibrate_strobe |=> state_q == CAL_IDLE;
  endproperty
  a_skip_tx: assert property (p_skip_tx) else $error("tx calibration not skipped");

  property p_rx_cal;
    state_q == CAL_IDLE && rx_entry |=> ##1 cal_busy_q;
  endproperty
  a_rx_cal: assert property (p_rx_cal) else $error("rx entry did not calibrate");

  property p_pump_off;
    cal_busy_q && pump_q.pump_off_during_cal && $stable(pump_q) |-> !pump_enable_q;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump on during calibration");

  property p_cur_ovr;
    cur_q.osc_current_override_en ##1 cur_q.osc_current_override_en
      |-> osc_current_a_q == $past(cur_q.osc_current_a_override)
          && osc_current_b_q == $past(cal_q.osc_current_constant);
  endproperty
  a_cur_ovr: assert property (p_cur_ovr) else $error("current override ignored");

  property p_dac_src;
    !ctrl_node_test_input && cal_q.ctrl_node_dac_select |=> ctrl_node_use_dac_q;
  endproperty
  a_dac_src: assert property (p_dac_src) else $error("dac not selected");

  property p_short_cal;
    state_q == CAL_IDLE && trigger && !cal_q.long_freq_measure
      |=> (state_q == CAL_MEASURE) [*8];
  endproperty
  a_short_cal: assert property (p_short_cal) else $error("calibration ended early");

  c_cal_run:    cover property (state_q == CAL_MEASURE ##1 state_q == CAL_IDLE);
  c_cal_settle: cover property (state_q == CAL_SETTLE ##1 state_q == CAL_IDLE);
  c_strobe:     cover property (state_q == CAL_IDLE && tx_calibrate_strobe);
  c_stepping:   cover property (stepping && !pump_q.pump_current_override_en);

endmodule
`default_nettype wire

//--- sctr_pkg.sv
// shared constants, register layouts and timing for the synth calibration test registers
package sctr_pkg;

  localparam int CLK_FREQ_MHZ = 125;
  localparam int CNT_W        = 16;
  localparam int ARRAY_STEPS  = 5;

  // register addresses on the configuration port
  localparam logic [5:0] ADDR_GAIN    = 6'h26;
  localparam logic [5:0] ADDR_ARRAY   = 6'h27;
  localparam logic [5:0] ADDR_CAL     = 6'h28;
  localparam logic [5:0] ADDR_CURRENT = 6'h29;
  localparam logic [5:0] ADDR_PUMP    = 6'h2A;

  // times in ns as printed, plus the chosen per-step settling time
  localparam int CAL_SHORT_NS = 37000;
  localparam int CAL_LONG_NS  = 57000;
  localparam int SETTLE_NS    = 1000;
  localparam int STEP0_NS     = 250;
  localparam int STEP1_NS     = 500;
  localparam int STEP2_NS     = 1000;
  localparam int STEP3_NS     = 4000;

  localparam logic [1:0] STEP_CODE0 = 2'h0;
  localparam logic [1:0] STEP_CODE1 = 2'h1;
  localparam logic [1:0] STEP_CODE2 = 2'h2;

  typedef struct packed {
    logic [5:0] rsvd;
    logic [4:0] mid_to_top_gain_step;
    logic [4:0] bottom_to_mid_gain_step;
  } sctr_gain_s;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       array_settle_extend;
    logic       array_override_en;
    logic [4:0] array_override_val;
    logic [4:0] array_cal_result;
  } sctr_array_s;

  typedef struct packed {
    logic       skip_tx_calibration;
    logic       long_freq_measure;
    logic [3:0] osc_current_reference;
    logic [5:0] osc_current_constant;
    logic       ctrl_node_dac_select;
    logic [2:0] ctrl_node_dac_value;
  } sctr_cal_s;

  typedef struct packed {
    logic       rsvd;
    logic [1:0] current_cal_speed;
    logic       osc_current_override_en;
    logic [5:0] osc_current_a_override;
    logic [5:0] osc_current_cal_result;
  } sctr_current_s;

  typedef struct packed {
    logic       pump_off_during_cal;
    logic       pump_current_override_en;
    logic       pump_force_up;
    logic       pump_force_down;
    logic       pump_pulse_mask;
    logic       phase_det_delay_select;
    logic [1:0] pump_step_interval;
    logic [3:0] pump_final_current;
    logic [3:0] pump_initial_current;
  } sctr_pump_s;

  localparam sctr_gain_s GAIN_RST = '{6'h00, 5'h09, 5'h0A};
  localparam sctr_array_s ARRAY_RST = '{4'h0, 1'h0, 1'h0, 5'h10, 5'h00};
  localparam sctr_cal_s CAL_RST = '{1'h0, 1'h1, 4'h4, 6'h00, 1'h0, 3'h2};
  localparam sctr_current_s CURRENT_RST = '{1'h0, 2'h0, 1'h0, 6'h18, 6'h00};
  localparam sctr_pump_s PUMP_RST =
    '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 4'hD, 4'hD};

  typedef enum logic [1:0] {CAL_IDLE, CAL_MEASURE, CAL_SETTLE} sctr_cal_e;

  // cycles for a time, never less than one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = ns * CLK_FREQ_MHZ / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic logic [CNT_W-1:0] step_cycles(input logic [1:0] code);
    int c;
    c = ns_to_cyc(STEP3_NS);
    if (code == STEP_CODE0) c = ns_to_cyc(STEP0_NS);
    else if (code == STEP_CODE1) c = ns_to_cyc(STEP1_NS);
    else if (code == STEP_CODE2) c = ns_to_cyc(STEP2_NS);
    return CNT_W'(c);
  endfunction

endpackage

//--- sctr_pump_stepper.sv
// charge pump current stepper run after each oscillator calibration
`timescale 1ns/100ps
`default_nettype none
module sctr_pump_stepper import sctr_pkg::*; (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // control
  input  wire logic       start,
  input  wire logic [1:0] interval,
  input  wire logic [3:0] initial_cur,
  input  wire logic [3:0] final_cur,
  // result
  output logic [3:0]      current_q,
  output logic            stepping_q
);

  logic [CNT_W-1:0] tick_q;

  // step timer restarts on every load and every step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= '0;
    end else if (start || !stepping_q || tick_q == '0) begin
      tick_q <= step_cycles(interval) - CNT_W'(1);
    end else begin
      tick_q <= tick_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      current_q  <= 4'h0;
      stepping_q <= 1'b0;
    end else if (start) begin
      current_q  <= initial_cur;
      stepping_q <= final_cur < initial_cur;
    end else if (stepping_q && tick_q == '0) begin
      current_q  <= current_q - 4'h1;
      stepping_q <= (current_q - 4'h1) > final_cur;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_step_one;
    !start |=> current_q == $past(current_q) || current_q == $past(current_q) - 4'h1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("pump current jumped");

  property p_step_hold;
    start && final_cur >= initial_cur |=> !stepping_q ##1 current_q == $past(current_q);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("pump stepped past hold");

  property p_step_fast;
    start && interval == STEP_CODE0 && final_cur < initial_cur
      |-> ##31 current_q == $past(initial_cur, 31)
          ##1 current_q == $past(initial_cur, 32) - 4'h1;
  endproperty
  a_step_fast: assert property (p_step_fast) else $error("step period wrong");

  c_step_end: cover property (stepping_q ##1 !stepping_q);

endmodule
`default_nettype wire

//--- sctr_tb.sv
// self-checking testbench for the synth calibration test register bank
`timescale 1ns/100ps
`default_nettype none
module testbench import sctr_pkg::*;;
  localparam int SHORT_CYC = 20;
  localparam int LONG_CYC  = 30;
  localparam int SETTLE_CYC = ARRAY_STEPS * (SETTLE_NS * CLK_FREQ_MHZ / 1000);

  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [5:0]  cfg_addr = 6'h00;
  logic [15:0] cfg_wdata = 16'h0000;
  logic        rx_entry = 1'b0;
  logic        tx_entry = 1'b0;
  logic        tx_calibrate_strobe = 1'b0;
  logic        ctrl_node_test_input = 1'b0;
  logic [4:0]  array_cal_in = 5'h00;
  logic [5:0]  current_cal_in = 6'h00;
  logic [15:0] cfg_rdata_q;
  logic [4:0]  mid_to_top_gain_step, bottom_to_mid_gain_step, array_setting_q;
  logic        cal_busy_q, settle_phase_q, ctrl_node_use_dac_q, pump_enable_q;
  logic [1:0]  current_cal_speed;
  logic [3:0]  osc_current_reference, pump_current_q;
  logic [5:0]  osc_current_a_q, osc_current_b_q;
  logic [2:0]  ctrl_node_dac_value;
  logic        pump_force_up, pump_force_down, pump_pulse_mask, phase_det_delay_select;
  int          err_count = 0;
  int          checks_done = 0;
  int          n;

  always #4 clock = ~clock;

  sctr_regs #(.CAL_SHORT_CYC(SHORT_CYC), .CAL_LONG_CYC(LONG_CYC)) sctr_regs_inst (
    .clock(clock), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .rx_entry(rx_entry), .tx_entry(tx_entry), .tx_calibrate_strobe(tx_calibrate_strobe),
    .ctrl_node_test_input(ctrl_node_test_input), .array_cal_in(array_cal_in),
    .current_cal_in(current_cal_in), .mid_to_top_gain_step(mid_to_top_gain_step),
    .bottom_to_mid_gain_step(bottom_to_mid_gain_step), .cal_busy_q(cal_busy_q),
    .settle_phase_q(settle_phase_q), .array_setting_q(array_setting_q),
    .current_cal_speed(current_cal_speed), .osc_current_reference(osc_current_reference),
    .osc_current_a_q(osc_current_a_q), .osc_current_b_q(osc_current_b_q),
    .ctrl_node_use_dac_q(ctrl_node_use_dac_q), .ctrl_node_dac_value(ctrl_node_dac_value),
    .pump_enable_q(pump_enable_q), .pump_current_q(pump_current_q),
    .pump_force_up(pump_force_up), .pump_force_down(pump_force_down),
    .pump_pulse_mask(pump_pulse_mask), .phase_det_delay_select(phase_det_delay_select)
  );

  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic fail_wait();
    err_count++;
    print_verdict();
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clock);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
    @(negedge clock);
    chk(cfg_rdata_q, exp);
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge clock);
  endtask

  // one-cycle event pulse, order {rx, tx, strobe}
  task automatic pulse(input logic [2:0] sel);
    @(posedge clock);
    {rx_entry, tx_entry, tx_calibrate_strobe} <= sel;
    @(posedge clock);
    {rx_entry, tx_entry, tx_calibrate_strobe} <= 3'h0;
  endtask

  // trigger, then measure the busy length and the pump enable seen during it
  task automatic run_cal(input logic [2:0] sel, input int exp_cyc, input logic en);
    logic bad;
    int   s;
    bad = 1'b0;
    s = 0;
    pulse(sel);
    n = 0;
    while (cal_busy_q !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 10) fail_wait();
    end
    n = 0;
    while (cal_busy_q === 1'b1) begin
      if (pump_enable_q !== en) bad = 1'b1;
      if (settle_phase_q === 1'b1) s++;
      n++;
      if (n > 2000) fail_wait();
      @(negedge clock);
    end
    chk(16'(n), 16'(exp_cyc));
    chk(16'(s), 16'((exp_cyc > LONG_CYC) ? SETTLE_CYC : 0));
    chk({15'h0, bad}, 16'h0000);
    chk({15'h0, pump_enable_q}, 16'h0001);
  endtask

  task automatic no_cal(input logic [2:0] sel);
    pulse(sel);
    repeat (6) begin
      @(negedge clock);
      chk({15'h0, cal_busy_q}, 16'h0000);
    end
  endtask

  task automatic wait_change();
    logic [3:0] prev;
    prev = pump_current_q;
    n = 0;
    while (pump_current_q === prev) begin
      @(negedge clock);
      n++;
      if (n > 1200) fail_wait();
    end
  endtask

  function automatic int step_exp(input int code);
    int t;
    t = (code == 0) ? STEP0_NS : (code == 1) ? STEP1_NS : (code == 2) ? STEP2_NS : STEP3_NS;
    return t * CLK_FREQ_MHZ / 1000;
  endfunction

  logic [15:0] rst_tab [5] = '{16'h012A, 16'h0200, 16'h5002, 16'h0600, 16'h82DD};

  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_chk(6'(ADDR_GAIN + i), rst_tab[i]);
    end
    chk({6'h00, mid_to_top_gain_step, bottom_to_mid_gain_step}, 16'h012A);
    wr(6'h2B, 16'h1234);
    rd_chk(6'h2B, 16'h0000);
    rd_chk(6'h25, 16'h0000);
    wr(ADDR_GAIN, 16'h0155);
    rd_chk(ADDR_GAIN, 16'h0155);
    chk({6'h00, mid_to_top_gain_step, bottom_to_mid_gain_step}, 16'h0155);
    wr(ADDR_CAL, 16'h66DD);
    rd_chk(ADDR_CAL, 16'h66DD);
    chk({7'h0, osc_current_reference, ctrl_node_dac_value, osc_current_b_q[1:0]},
        16'h0135);
    chk({10'h0, osc_current_b_q}, 16'h002D);
    chk({15'h0, ctrl_node_use_dac_q}, 16'h0001);
    @(posedge clock);
    ctrl_node_test_input <= 1'b1;
    idle(3);
    chk({15'h0, ctrl_node_use_dac_q}, 16'h0000);
    @(posedge clock);
    ctrl_node_test_input <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CURRENT, 16'(c << 13) | 16'h063F);
      rd_chk(ADDR_CURRENT, 16'(c << 13) | 16'h0600);
      chk({14'h0, current_cal_speed}, 16'(c));
    end
    wr(ADDR_PUMP, 16'hBEDD);
    rd_chk(ADDR_PUMP, 16'hBEDD);
    chk({12'h0, pump_force_up, pump_force_down, pump_pulse_mask, phase_det_delay_select},
        16'h000F);
    wr(ADDR_PUMP, 16'h82DD);
    idle(1);
    chk({12'h0, pump_force_up, pump_force_down, pump_pulse_mask, phase_det_delay_select},
        16'h0000);
    wr(ADDR_CURRENT, 16'h0600);
    wr(ADDR_ARRAY, 16'h021F);
    rd_chk(ADDR_ARRAY, 16'h0200);
    @(posedge clock);
    array_cal_in <= 5'h13;
    current_cal_in <= 6'h2A;
    run_cal(3'h4, LONG_CYC, 1'b0);
    rd_chk(ADDR_ARRAY, 16'h0213);
    rd_chk(ADDR_CURRENT, 16'h062A);
    chk({5'h0, array_setting_q, osc_current_a_q}, 16'h04EA);
    wr(ADDR_CAL, 16'h26DD);
    run_cal(3'h2, SHORT_CYC, 1'b0);
    wr(ADDR_PUMP, 16'h02DD);
    run_cal(3'h4, SHORT_CYC, 1'b1);
    wr(ADDR_ARRAY, 16'h0A00);
    run_cal(3'h4, SHORT_CYC + SETTLE_CYC, 1'b1);
    wr(ADDR_ARRAY, 16'h0200);
    wr(ADDR_CAL, 16'hA6DD);
    no_cal(3'h2);
    run_cal(3'h1, SHORT_CYC, 1'b1);
    wr(ADDR_CAL, 16'h26DD);
    wr(ADDR_ARRAY, 16'h0560);
    wr(ADDR_CURRENT, 16'h11C0);
    idle(3);
    chk({11'h0, array_setting_q}, 16'h000B);
    chk({4'h0, osc_current_a_q, osc_current_b_q}, 16'h01ED);
    wr(ADDR_ARRAY, 16'h0200);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_PUMP, 16'h8013 | 16'(c << 8));
      run_cal(3'h4, SHORT_CYC, 1'b0);
      chk({12'h0, pump_current_q}, 16'h0003);
      wait_change();
      chk({12'h0, pump_current_q}, 16'h0002);
      wait_change();
      chk(16'(n), 16'(step_exp(c)));
      chk({12'h0, pump_current_q}, 16'h0001);
      idle(step_exp(c) + 5);
      chk({12'h0, pump_current_q}, 16'h0001);
    end
    wr(ADDR_PUMP, 16'h8064);
    run_cal(3'h4, SHORT_CYC, 1'b0);
    chk({12'h0, pump_current_q}, 16'h0004);
    idle(40);
    chk({12'h0, pump_current_q}, 16'h0004);
    wr(ADDR_PUMP, 16'hC019);
    idle(3);
    chk({12'h0, pump_current_q}, 16'h0009);
    print_verdict();
  end
endmodule
`default_nettype wire
